// [hdl/mcc_ctrl.sv]
// memory and i/o chip-select controller top
`timescale 1ns/1ns
`default_nettype none
module mcc_ctrl
    import mcc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // request port from the arbitrated core/dma/pci bus
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_src,
    input wire logic req_write,
    input wire logic req_instr,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [2:0] req_beats,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic [DATA_W-1:0] core_rdata,
    output logic core_ack,
    // dma/pci write data into the controller
    input wire logic [DATA_W-1:0] wfifo_data,
    input wire logic wfifo_valid,
    output logic wfifo_ready,
    // dma/pci read data out
    output logic [DATA_W-1:0] rfifo_data,
    output logic rfifo_valid,
    input wire logic rfifo_ready,
    // per-region configuration
    input wire logic [ADDR_W-1:0] base0,
    input wire logic [ADDR_W-1:0] base1,
    input wire logic [ADDR_W-1:0] mask0,
    input wire logic [ADDR_W-1:0] mask1,
    input wire logic [2*NUM_REGIONS-1:0] mem_type,
    input wire logic [2*NUM_REGIONS-1:0] port_width,
    input wire logic [WAIT_W*NUM_REGIONS-1:0] rd_waits,
    input wire logic [WAIT_W*NUM_REGIONS-1:0] wr_waits,
    output logic no_match,
    // memory pins
    output logic [MEM_ADDR_HI:0] mem_addr,
    output logic [NUM_REGIONS-1:0] mem_cs_n,
    output logic mem_oe_n,
    output logic [3:0] mem_we_n,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe,
    output logic xcvr_oe_n,
    output logic xcvr_dir_n,
    // trace outputs
    output logic trace_start_n,
    output logic trace_ack_n,
    output logic trace_dma_n,
    output logic trace_instr_n,
    output logic xfer_direction_n,
    output logic xfer_direction_oe
);
    // ----------------------------------------------------------------
    // input synchroniser for the data pins
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    always_ff @(posedge mclk) begin
        if (ce) begin
            data_meta <= mem_data_in;
            data_sync <= data_meta;
        end
    end

    // ----------------------------------------------------------------
    // region decode
    // ----------------------------------------------------------------
    logic [NUM_REGIONS-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g++) begin : g_dec
            if (g < PROG_REGIONS) begin : g_prog
                logic [ADDR_W-1:0] b;
                logic [ADDR_W-1:0] m;
                assign b = (g == 0) ? base0 : base1;
                assign m = ((g == 0) ? mask0 : mask1) | ADDR_W'((1 << MASK_LSB) - 1);
                assign hit[g] = ((req_addr & ~m) == (b & ~m));
            end else begin : g_fix
                localparam logic [ADDR_W-1:0] FB = FIXED_BASE2 + ADDR_W'(g - 2) * FIXED_STEP;
                assign hit[g] = (req_addr[ADDR_W-1:FIXED_SIZE_LSB] == FB[ADDR_W-1:FIXED_SIZE_LSB]);
            end
        end
    endgenerate

    // lowest region wins so only one select is possible
    logic [NUM_REGIONS-1:0] sel_onehot;
    assign sel_onehot = hit & (~hit + 1'b1);
    assign no_match = req_valid && (hit == '0);

    // ----------------------------------------------------------------
    // transaction state
    // ----------------------------------------------------------------
    mcc_state_t state;
    mcc_state_t next_state;
    logic [NUM_REGIONS-1:0] cur_sel;
    logic [2:0] cur_reg;
    logic [1:0] cur_src;
    logic cur_write;
    logic cur_instr;
    logic [ADDR_W-1:0] cur_addr;
    logic [1:0] start_word;
    logic [1:0] beat;
    logic [1:0] last_beat;
    logic [WAIT_W-1:0] wcnt;
    logic [WAIT_W-1:0] cur_waits;
    logic [1:0] word_idx;
    logic [1:0] addr_beat;
    logic [MEM_ADDR_HI:0] lin_addr;
    logic rfifo_in_ready;
    logic is_dma_next;
    logic [2:0] hit_idx;
    logic fifo_rd_ok;
    logic fifo_wr_ok;
    logic is_dma;

    always_comb begin
        hit_idx = '0;
        for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
            if (sel_onehot[i]) begin
                hit_idx = 3'(i);
            end
        end
    end

    assign is_dma = (cur_src != SRC_CORE);
    assign cur_waits = cur_write ? wr_waits[cur_reg*WAIT_W +: WAIT_W] : rd_waits[cur_reg*WAIT_W +: WAIT_W];
    // leaving a beat the pins already show the next word, covering the input synchroniser delay
    assign addr_beat = (state == MCC_BEAT) ? beat + 1'b1 : beat;
    assign lin_addr = cur_addr[MEM_ADDR_HI:0] + {addr_beat, 2'b00};
    // core reads walk subblock order, everything else is linear
    assign word_idx = (!is_dma && !cur_write) ? (start_word ^ addr_beat) : lin_addr[3:2];
    assign fifo_wr_ok = !is_dma || !cur_write || wfifo_valid;
    assign fifo_rd_ok = !is_dma || cur_write || rfifo_in_ready;
    assign req_ready = (state == MCC_IDLE) && ce;

    logic rfifo_push;
    assign rfifo_push = (state == MCC_BEAT) && is_dma && !cur_write;

    always_comb begin
        next_state = state;
        unique case (state)
            MCC_IDLE: begin
                if (req_valid && hit != '0) begin
                    next_state = MCC_START;
                end
            end
            MCC_START: next_state = MCC_WAIT;
            MCC_WAIT: begin
                if (wcnt == '0 && fifo_wr_ok && fifo_rd_ok) begin
                    next_state = MCC_BEAT;
                end
            end
            MCC_BEAT: begin
                if (beat == last_beat) begin
                    next_state = MCC_HOLD;
                end else begin
                    next_state = MCC_WAIT;
                end
            end
            MCC_HOLD: next_state = MCC_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= MCC_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cur_sel <= '0;
            cur_reg <= '0;
            cur_src <= SRC_CORE;
            cur_write <= 1'b0;
            cur_instr <= 1'b0;
            cur_addr <= '0;
            start_word <= '0;
            last_beat <= '0;
        end else if (ce && state == MCC_IDLE && req_valid && hit != '0) begin
            cur_sel <= sel_onehot;
            cur_reg <= hit_idx;
            cur_src <= req_src;
            cur_write <= req_write;
            cur_instr <= req_instr && (req_src == SRC_CORE);
            cur_addr <= req_addr;
            start_word <= req_addr[3:2];
            last_beat <= (req_beats > 3'(MAX_BEATS)) ? 2'(MAX_BEATS - 1) :
                         (req_beats == '0) ? '0 : 2'(req_beats - 3'd1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            beat <= '0;
            wcnt <= '0;
        end else if (ce) begin
            if (state == MCC_START || state == MCC_HOLD) begin
                wcnt <= cur_waits;
                beat <= '0;
            end else if (state == MCC_WAIT && wcnt != '0) begin
                wcnt <= wcnt - 1'b1;
            end else if (state == MCC_BEAT) begin
                wcnt <= cur_waits;
                beat <= beat + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // memory pins
    // ----------------------------------------------------------------
    logic active;
    logic [1:0] pw;
    assign active = (state == MCC_WAIT) || (state == MCC_BEAT);
    assign pw = port_width[cur_reg*2 +: 2];

    always_ff @(posedge mclk) begin
        if (srst) begin
            mem_cs_n <= '1;
            mem_oe_n <= 1'b1;
            mem_we_n <= '1;
            mem_addr <= '0;
        end else if (ce) begin
            if (next_state == MCC_WAIT || next_state == MCC_BEAT) begin
                mem_cs_n <= ~cur_sel;
                mem_addr <= {(!is_dma && !cur_write) ? cur_addr[MEM_ADDR_HI:4] : lin_addr[MEM_ADDR_HI:4],
                             word_idx, 2'b00};
                mem_oe_n <= cur_write;
                if (pw == PORT_W8 || pw == PORT_W16) begin
                    mem_we_n <= {2'b11, cur_addr[1:0]};
                end else if (cur_write && (mem_type[cur_reg*2 +: 2] != MTYPE_DPM || next_state == MCC_BEAT)) begin
                    mem_we_n <= '0;
                end else begin
                    mem_we_n <= '1;
                end
            end else begin
                mem_cs_n <= '1;
                mem_oe_n <= 1'b1;
                mem_we_n <= '1;
            end
        end
    end

    // ----------------------------------------------------------------
    // data path and fifos
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] wdata_reg;
    assign wfifo_ready = (state == MCC_BEAT) && is_dma && cur_write && ce;

    always_ff @(posedge mclk) begin
        if (srst) begin
            mem_data_out <= '0;
            mem_data_oe <= 1'b0;
            core_rdata <= '0;
            core_ack <= 1'b0;
            wdata_reg <= '0;
        end else if (ce) begin
            core_ack <= (state == MCC_BEAT) && !is_dma;
            if (state == MCC_IDLE && req_valid) begin
                wdata_reg <= req_wdata;
                // start cycle carries the quad address for core requests, the word address for dma/pci, for the trace
                mem_data_out <= {req_addr[ADDR_W-1:4], (req_src != SRC_CORE) ? req_addr[3:2] : 2'b00, 2'b00};
                mem_data_oe <= (hit != '0);
            end else if (active && cur_write) begin
                mem_data_out <= is_dma ? wfifo_data : wdata_reg;
                mem_data_oe <= 1'b1;
            end else begin
                mem_data_oe <= 1'b0;
            end
            if (state == MCC_BEAT && !is_dma && !cur_write) begin
                core_rdata <= data_sync;
            end
        end
    end

    mcc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rfifo (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .in_data(data_sync),
        .in_valid(rfifo_push),
        .in_ready(rfifo_in_ready),
        .out_data(rfifo_data),
        .out_valid(rfifo_valid),
        .out_ready(rfifo_ready)
    );

    // ----------------------------------------------------------------
    // transceiver and trace outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            xcvr_oe_n <= 1'b1;
            xcvr_dir_n <= 1'b1;
            trace_start_n <= 1'b1;
            trace_ack_n <= 1'b1;
            trace_dma_n <= 1'b1;
            trace_instr_n <= 1'b1;
            xfer_direction_n <= 1'b1;
            xfer_direction_oe <= 1'b0;
        end else if (ce) begin
            xcvr_oe_n <= !(next_state == MCC_WAIT || next_state == MCC_BEAT);
            xcvr_dir_n <= !cur_write;
            trace_start_n <= !(next_state == MCC_START);
            trace_ack_n <= !(next_state == MCC_BEAT);
            if (next_state == MCC_START) begin
                trace_dma_n <= is_dma_next;
                trace_instr_n <= !(req_instr && req_src == SRC_CORE);
            end
            // direction valid the clock after start, held to the end
            if (state == MCC_START) begin
                xfer_direction_n <= cur_write;
                xfer_direction_oe <= 1'b1;
            end else if (next_state == MCC_IDLE) begin
                xfer_direction_n <= 1'b1;
                xfer_direction_oe <= 1'b0;
            end
        end
    end

    assign is_dma_next = !(req_src != SRC_CORE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_start;
        !trace_start_n;
    endsequence

    a_start_one_clk: assert property (@(posedge mclk) disable iff (srst || !ce)
        s_start |=> trace_start_n)
        else $error("trace start longer than one clock");
    a_dir_after_start: assert property (@(posedge mclk) disable iff (srst || !ce)
        s_start |=> xfer_direction_oe)
        else $error("direction not driven after start");
    a_cs_onehot: assert property (@(posedge mclk) disable iff (srst)
        $countones(~mem_cs_n) <= 1)
        else $error("more than one chip select");
    a_ack_per_beat: assert property (@(posedge mclk) disable iff (srst || !ce)
        !trace_ack_n |-> !core_ack && state == MCC_BEAT)
        else $error("trace ack outside beat");
    a_nomatch_idle: assert property (@(posedge mclk) disable iff (srst || !ce)
        (state == MCC_IDLE && no_match) |=> state == MCC_IDLE)
        else $error("access started without match");
    a_wait_count: assert property (@(posedge mclk) disable iff (srst || !ce)
        (state == MCC_WAIT && wcnt != '0) |=> state == MCC_WAIT)
        else $error("beat before wait states elapsed");
    a_cs_in_beat: assert property (@(posedge mclk) disable iff (srst || !ce)
        state == MCC_BEAT |-> mem_cs_n == ~cur_sel)
        else $error("chip select not held on beat");
    a_core_subblock: assert property (@(posedge mclk) disable iff (srst)
        (state == MCC_BEAT && !is_dma && !cur_write) |-> mem_addr[3:2] == (start_word ^ beat))
        else $error("core burst order wrong");
endmodule
`default_nettype wire

// [hdl/mcc_pkg.sv]
// constants and types shared by the memory and i/o chip-select controller
// Summary of operation
// - narrow accesses put byte address on write enables
// - direction valid one clock after start, whole transaction
// - direction never early for dma transactions
// - trace acknowledge after programmed wait states elapse
// - trace acknowledge pulses once per burst beat
// - six regions, one active-low chip select each
// - regions 0 and 1 programmable decoders
// - regions 2 to 5 fixed 32 MB ranges
// - per-region type and read/write wait states
// - per-region port width 8, 16, 32, interleaved
// - compare address to all regions, drive on match
// - single and up to four-word bursts
// - core burst reads use subblock order
// - dma bursts increment word address linearly
// - dma/pci data moves through requester fifo
// - base plus page mask decides region 0/1 hit
// - transceiver enable and direction controls generated
// - trace start low exactly one clock per transaction
// - start cycle puts quad address (word address for dma/pci) on data lines
package mcc_pkg;
    localparam int NUM_REGIONS = 6;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int MEM_ADDR_HI = 25;
    localparam int WAIT_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int MAX_BEATS = 4;
    localparam int PROG_REGIONS = 2;
    localparam int MASK_LSB = 16;
    // fixed regions 2..5 base addresses, 32 MB each
    localparam logic [ADDR_W-1:0] FIXED_BASE2 = 32'h1000_0000;
    localparam logic [ADDR_W-1:0] FIXED_STEP = 32'h0200_0000;
    localparam int FIXED_SIZE_LSB = 25;
    localparam logic [1:0] PORT_W8 = 2'h0;
    localparam logic [1:0] PORT_W16 = 2'h1;
    localparam logic [1:0] PORT_W32 = 2'h2;
    localparam logic [1:0] PORT_WIL = 2'h3;
    localparam logic [1:0] SRC_CORE = 2'h0;
    localparam logic [1:0] SRC_DMA = 2'h1;
    localparam logic [1:0] SRC_PCI = 2'h2;
    localparam logic [1:0] MTYPE_DPM = 2'h3;
    typedef enum logic [4:0] {
        MCC_IDLE = 5'b00001,
        MCC_START = 5'b00010,
        MCC_WAIT = 5'b00100,
        MCC_BEAT = 5'b01000,
        MCC_HOLD = 5'b10000
    } mcc_state_t;
endpackage

// [hdl/mcc_fifo.sv]
// data fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module mcc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready && ce;
    assign pop = out_valid && out_ready && ce;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge mclk) disable iff (srst)
        (count == (AW+1)'(DEPTH)) |-> !push)
        else $error("fifo pushed while full");
endmodule
`default_nettype wire

// [testbench/mcc_mem_model.sv]
// external memory model answering reads with an address-derived pattern
`timescale 1ns/1ns
`default_nettype none
module mcc_mem_model (
    input wire logic mclk,
    input wire logic [5:0] mem_cs_n,
    input wire logic mem_oe_n,
    input wire logic mem_data_oe,
    input wire logic [25:0] mem_addr,
    output logic [31:0] mem_data_in
);
    logic [31:0] last = 32'h0000_0000;
    logic sel;
    // ----------------------------------------
    // read data
    // ----------------------------------------
    assign sel = (mem_cs_n != 6'h3f) && !mem_oe_n && !mem_data_oe;
    // a released bus shows a pattern that changes every cycle
    always @(posedge mclk) begin
        last <= mem_data_in;
    end
    // word address comes from the address pins only
    assign mem_data_in = sel ? {mem_addr[25:2], 8'h3c} : ~last;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the memory and i/o chip-select controller
`timescale 1ns/1ns
`default_nettype none
module tb
    import mcc_pkg::*;
;
    typedef struct packed {logic [1:0] src; logic wr; logic [31:0] addr; logic [2:0] beats; logic [2:0] cs;} mcc_row_t;
    logic mclk, srst = 1'b1, ce = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_instr = 1'b0;
    logic wfifo_valid = 1'b1, rfifo_ready = 1'b1;
    logic [1:0] req_src = 2'h0;
    logic [2:0] req_beats = 3'h1;
    logic [31:0] req_addr = 32'h0000_0000, req_wdata = 32'h0000_0000, wcnt = 32'h0000_0000;
    logic [31:0] base0 = 32'h0000_0000, mask0 = 32'h0000_ffff, base1 = 32'h0400_0000, mask1 = 32'h007f_ffff;
    logic [11:0] mem_type = 12'h000, port_width = {PORT_W16, PORT_W8, {4{PORT_W32}}};
    logic [23:0] rd_waits = 24'h65_4321, wr_waits = 24'h12_3456;
    logic req_ready, core_ack, wfifo_ready, rfifo_valid, no_match, mem_oe_n, mem_data_oe;
    logic xcvr_oe_n, xcvr_dir_n, trace_start_n, trace_ack_n, trace_dma_n, trace_instr_n;
    logic xfer_direction_n, xfer_direction_oe;
    logic [31:0] core_rdata, wfifo_data, rfifo_data, mem_data_in, mem_data_out;
    logic [25:0] mem_addr;
    logic [5:0] mem_cs_n;
    logic [3:0] mem_we_n;
    logic [31:0] got_c[$], got_r[$], exp_c[$], exp_r[$];
    int n_mismatch = 0, comparisons = 0;
    mcc_row_t rows [14] = '{
        '{SRC_CORE, 1'b0, 32'h0000_0100, 3'h1, 3'h0}, '{SRC_CORE, 1'b1, 32'h0400_0010, 3'h1, 3'h1},
        '{SRC_CORE, 1'b0, 32'h1000_0004, 3'h4, 3'h2}, '{SRC_CORE, 1'b0, 32'h1200_0008, 3'h4, 3'h3},
        '{SRC_CORE, 1'b0, 32'h047f_fffc, 3'h4, 3'h1}, '{SRC_CORE, 1'b0, 32'h0000_0000, 3'h4, 3'h0},
        '{SRC_DMA, 1'b0, 32'h1000_0008, 3'h4, 3'h2}, '{SRC_DMA, 1'b1, 32'h1200_0020, 3'h3, 3'h3},
        '{SRC_PCI, 1'b0, 32'h11ff_fff8, 3'h2, 3'h2}, '{SRC_PCI, 1'b1, 32'h0000_fffc, 3'h1, 3'h0},
        '{SRC_CORE, 1'b1, 32'h1400_0003, 3'h1, 3'h4}, '{SRC_CORE, 1'b1, 32'h1600_0006, 3'h1, 3'h5},
        '{SRC_DMA, 1'b1, 32'h0400_0000, 3'h4, 3'h1}, '{SRC_DMA, 1'b0, 32'h1200_0040, 3'h4, 3'h3}};

    assign wfifo_data = 32'hc0de_0000 + wcnt;

    mcc_ctrl dut (.mclk, .srst, .ce, .req_valid, .req_ready, .req_src, .req_write, .req_instr, .req_addr,
        .req_beats, .req_wdata, .core_rdata, .core_ack, .wfifo_data, .wfifo_valid, .wfifo_ready,
        .rfifo_data, .rfifo_valid, .rfifo_ready, .base0, .base1, .mask0, .mask1, .mem_type, .port_width,
        .rd_waits, .wr_waits, .no_match, .mem_addr, .mem_cs_n, .mem_oe_n, .mem_we_n, .mem_data_in,
        .mem_data_out, .mem_data_oe, .xcvr_oe_n, .xcvr_dir_n, .trace_start_n, .trace_ack_n, .trace_dma_n,
        .trace_instr_n, .xfer_direction_n, .xfer_direction_oe);

    mcc_mem_model mem (.mclk, .mem_cs_n, .mem_oe_n, .mem_data_oe, .mem_addr, .mem_data_in);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ----------------------------------------
    // capture of returned data
    // ----------------------------------------
    always @(posedge mclk) begin
        if (core_ack === 1'b1 && !req_write) got_c.push_back(core_rdata);
        if (rfifo_valid === 1'b1 && rfifo_ready === 1'b1) got_r.push_back(rfifo_data);
        if (wfifo_valid && wfifo_ready === 1'b1) wcnt <= wcnt + 32'h0000_0001;
    end

    // ----------------------------------------
    // compare and close tasks
    // ----------------------------------------
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // request and transaction tasks
    // ----------------------------------------
    task automatic send(input mcc_row_t r);
        int n;
        {req_src, req_write, req_addr, req_beats} = {r.src, r.wr, r.addr, r.beats};
        req_wdata = ~r.addr;
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        chk_bit(req_ready, 1'b1);
        #1;
        req_valid = 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        chk_vec({26'h0, mem_cs_n}, 32'h0000_003f);
        #1;
    endtask

    task automatic xact(input mcc_row_t r);
        int n, s, acks;
        logic [31:0] a, wb;
        logic [3:0] wt;
        logic wide;
        wt = r.wr ? wr_waits[r.cs*4+:4] : rd_waits[r.cs*4+:4];
        wide = port_width[r.cs*2+:2] == PORT_W32;
        wb = wcnt;
        send(r);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (trace_start_n !== 1'b0 && n < 20);
        chk_bit(trace_start_n, 1'b0);
        chk_vec({mem_data_out[31:4], r.src == SRC_DMA ? mem_data_out[3:2] : 2'h0, 2'h0},
            {r.addr[31:4], r.src == SRC_DMA ? r.addr[3:2] : 2'h0, 2'h0});
        if (r.src == SRC_DMA) chk_bit(xfer_direction_oe & ~xfer_direction_n, 1'b0);
        chk_bit(trace_dma_n, r.src == SRC_CORE);
        s = 0;
        acks = 0;
        while (acks < r.beats && s < 200) begin
            @(posedge mclk);
            s++;
            if (s == 1) chk_bit(trace_start_n, 1'b1);
            chk_vec({26'h0, mem_cs_n}, {26'h0, 6'h3f ^ (6'h01 << r.cs)});
            chk_bit(xfer_direction_n, r.wr);
            chk_bit(xfer_direction_oe, 1'b1);
            if (trace_ack_n === 1'b0) begin
                if (acks == 0) chk_vec(32'(s), 32'(wt) + 32'h0000_0002);
                chk_bit(mem_data_oe, r.wr);
                chk_bit(xcvr_oe_n, 1'b0);
                chk_bit(xcvr_dir_n, !r.wr);
                chk_bit(mem_oe_n, r.wr);
                if (!wide) chk_vec({30'h0, mem_we_n[1:0]}, {30'h0, r.addr[1:0]});
                if (r.wr && wide) chk_vec(mem_data_out, r.src == SRC_CORE ? ~r.addr : 32'hc0de_0000 + wb + 32'(acks));
                a = (r.src == SRC_CORE) ? {r.addr[31:4], r.addr[3:0] ^ 4'(acks * 4)} : r.addr + 32'(acks * 4);
                if (!r.wr && r.src == SRC_CORE) exp_c.push_back({a[25:2], 8'h3c});
                if (!r.wr && r.src != SRC_CORE) exp_r.push_back({a[25:2], 8'h3c});
                acks++;
            end
        end
        chk_vec(32'(acks), 32'(r.beats));
        wait_idle();
    endtask

    task automatic drain();
        repeat (8) @(posedge mclk);
        #1;
        chk_vec(32'(got_c.size()), 32'(exp_c.size()));
        chk_vec(32'(got_r.size()), 32'(exp_r.size()));
        while (got_c.size() > 0 && exp_c.size() > 0) chk_vec(got_c.pop_front(), exp_c.pop_front());
        while (got_r.size() > 0 && exp_r.size() > 0) chk_vec(got_r.pop_front(), exp_r.pop_front());
        got_c.delete();
        got_r.delete();
        exp_c.delete();
        exp_r.delete();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        repeat (8) @(posedge mclk);
        #1;
        srst = 1'b0;
        @(posedge mclk);
        #1;
        chk_vec({26'h0, mem_cs_n}, 32'h0000_003f);
        chk_bit(trace_start_n, 1'b1);
        chk_bit(trace_ack_n, 1'b1);
        chk_bit(mem_data_oe, 1'b0);
        $display("reset test done");
        for (int i = 0; i < 14; i++) begin
            xact(rows[i]);
            drain();
            $display("row %0d done", i);
        end
        // unmapped addresses, one just past the 64K region
        req_valid = 1'b1;
        for (int j = 0; j < 2; j++) begin
            req_addr = (j != 0) ? 32'h2000_0000 : 32'h0001_0000;
            n = 0;
            repeat (20) begin
                @(posedge mclk);
                if (trace_start_n !== 1'b1 || mem_cs_n !== 6'h3f) n++;
            end
            chk_bit(no_match, 1'b1);
            chk_vec(32'(n), 32'h0000_0000);
            #1;
        end
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
        $display("unmapped test done");
        // fill the read buffer with the consumer stalled
        rfifo_ready = 1'b0;
        xact(rows[6]);
        xact(rows[13]);
        send('{SRC_DMA, 1'b0, 32'h0000_0200, 3'h1, 3'h0});
        n = 0;
        repeat (30) begin
            @(posedge mclk);
            if (trace_ack_n === 1'b0) n++;
        end
        chk_vec(32'(n), 32'h0000_0000);
        #1;
        rfifo_ready = 1'b1;
        wait_idle();
        exp_r.push_back({24'h00_0080, 8'h3c});
        drain();
        $display("buffer test done");
        close_out();
    end

    initial begin
        #(40 * 8000);
        n_mismatch++;
        $display("ERROR at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
`default_nettype wire
